// file: dv/sdr_diag_chk.sv
/*
  Port checker of the diagnostic reporter.
  Assumes one clock domain; bound to the design by the statement at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
module sdr_diag_chk (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  // Requests seen
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic I_PARAM_WR,
  input wire logic [3:0] I_PARAM,
  input wire logic [3:0] I_WARN,
  input wire logic [9:0] I_FAULT,
  input wire logic I_CURRENT_NO_ON,
  input wire logic I_SELFTEST_FAIL,
  input wire logic I_LINK_OK,
  // Answers watched
  input wire logic O_AVS_WAITREQUEST,
  input wire logic [3:0] O_ECHO,
  input wire logic O_ECHO_VALID,
  input wire logic O_PERIPHERAL_FAULT_STATUS_BIT,
  input wire logic O_FAULT_LAMP,
  input wire logic O_STATE_RED,
  input wire logic O_STATE_GREEN,
  input wire logic O_DEVICE_RED,
  input wire logic O_DEVICE_GREEN
);
  // =====
  // Properties
  // =====
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  logic [4:0] lamps; // Fault, state red/green, device red/green
  assign lamps = {O_FAULT_LAMP, O_STATE_RED, O_STATE_GREEN, O_DEVICE_RED, O_DEVICE_GREEN};
  echo_valid_a: assert property (I_PARAM_WR |=> O_ECHO_VALID)
    else $error("Echo valid missing after parameter write");
  echo_hold_a: assert property (!I_PARAM_WR |=> !O_ECHO_VALID && $stable(O_ECHO))
    else $error("Echo changed without a parameter write");
  echo_none_a: assert property (I_PARAM_WR && !I_PARAM[0] && I_WARN == 4'h0
    && $past(I_WARN) == 4'h0 && $past(I_WARN, 2) == 4'h0 |=> O_ECHO == 4'h0)
    else $error("Empty warning class did not echo zero");
  status_bit_a: assert property (|I_FAULT |=> O_PERIPHERAL_FAULT_STATUS_BIT)
    else $error("Status bit low with a fault pending");
  err_latch_a: assert property (I_SELFTEST_FAIL |-> ##2 O_PERIPHERAL_FAULT_STATUS_BIT [*8])
    else $error("Device error did not stay latched");
  all_red_a: assert property (I_CURRENT_NO_ON |-> ##3 lamps == 5'h1a)
    else $error("Current without on command not all red");
  link_lost_a: assert property ((!I_LINK_OK && !O_PERIPHERAL_FAULT_STATUS_BIT
    && !I_CURRENT_NO_ON && !I_SELFTEST_FAIL) [*3] |=> lamps == 5'h10)
    else $error("Link lost lamps wrong");
  bus_wait_a: assert property (O_AVS_WAITREQUEST && (I_AVS_READ || I_AVS_WRITE)
    |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST)
    else $error("Bus answer not a single wait state");
endmodule

bind sdr_diag_reporter sdr_diag_chk chk_u (
  .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_AVS_READ(I_AVS_READ),
  .I_AVS_WRITE(I_AVS_WRITE), .I_PARAM_WR(I_PARAM_WR), .I_PARAM(I_PARAM),
  .I_WARN(I_WARN), .I_FAULT(I_FAULT), .I_CURRENT_NO_ON(I_CURRENT_NO_ON),
  .I_SELFTEST_FAIL(I_SELFTEST_FAIL), .I_LINK_OK(I_LINK_OK),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_ECHO(O_ECHO), .O_ECHO_VALID(O_ECHO_VALID),
  .O_PERIPHERAL_FAULT_STATUS_BIT(O_PERIPHERAL_FAULT_STATUS_BIT),
  .O_FAULT_LAMP(O_FAULT_LAMP), .O_STATE_RED(O_STATE_RED), .O_STATE_GREEN(O_STATE_GREEN),
  .O_DEVICE_RED(O_DEVICE_RED), .O_DEVICE_GREEN(O_DEVICE_GREEN)
);
`default_nettype wire

// file: dv/sdr_master_model.sv
/*
  Behavioural fieldbus master: sends parameter writes, takes the echo and
  mirrors the status bit. Assumes the echo answers within a few cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module sdr_master_model (
  // Clock
  input wire logic i_clk,
  // Answers from the starter
  input wire logic i_echo_valid,
  input wire logic [3:0] i_echo,
  input wire logic i_status_bit,
  // Requests to the starter
  output logic o_param_wr,
  output logic [3:0] o_param,
  // Fault list kept by the master
  output logic o_fault_list
);
  logic ab_flag = 1'b0; // Half-address select, owned here, not by the user
  initial begin
    o_param_wr = 1'b0;
    o_param = 4'h0;
    o_fault_list = 1'b0;
  end
  // Mirror the status bit every cycle so the controller can poll it
  always @(posedge i_clk) begin
    o_fault_list <= i_status_bit;
  end
  // One parameter write with all four bits, then wait for the echo
  task automatic ask(input logic cls, input logic [1:0] junk, output logic [3:0] code);
    int n;
    n = 0;
    @(posedge i_clk);
    o_param_wr <= 1'b1;
    o_param <= {ab_flag, junk, cls};
    @(posedge i_clk);
    o_param_wr <= 1'b0;
    o_param <= ~{ab_flag, junk, cls}; // Idle lines must not look valid
    ab_flag = ~ab_flag;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_echo_valid !== 1'b1 && n < 8);
    code = (n < 8) ? i_echo : 4'hx;
  endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
/*
  Self-checking bench of the diagnostic reporter.
  Assumes the bound checker and the master model beside the design.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // =====
  // Stimulus and observed signals
  // =====
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic we = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic wait_req;
  logic pwr;
  logic [3:0] par;
  logic [3:0] echo;
  logic ev;
  logic sbit;
  logic flist;
  logic [3:0] warn = 4'h0;
  logic [9:0] fault = 10'h0;
  logic motor = 1'b0;
  logic mabort = 1'b0;
  logic itrip = 1'b0;
  logic cno = 1'b0;
  logic stf = 1'b0;
  logic [5:0] syserr = 6'h0;
  logic [3:0] gwarn = 4'h0;
  logic link = 1'b1;
  logic clk_en = 1'b1;
  logic [4:0] lamps; // Fault, state red/green, device red/green
  int err_total = 0;
  int check_count = 0;
  // Echo codes, highest priority at the lowest index
  localparam logic [15:0] WCODE = {4'hc, 4'h4, 4'ha, 4'hb};
  localparam logic [39:0] FCODE = {4'hf, 4'h3, 4'hd, 4'h4, 4'h2, 4'hc, 4'h9, 4'he, 4'h6, 4'ha};
  always #5 clk = ~clk;
  // Short blink counts keep lamp checks brief
  sdr_diag_reporter #(.FLASH_HALF(4), .FLICKER_HALF(2)) dut_u (
    .I_CLK(clk), .I_RESET_N(rst_n), .I_CLK_EN(clk_en), .I_AVS_ADDRESS(addr),
    .I_AVS_READ(rd), .I_AVS_WRITE(we), .I_AVS_WRITEDATA(wd), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(wait_req), .I_PARAM_WR(pwr), .I_PARAM(par), .O_ECHO(echo),
    .O_ECHO_VALID(ev), .O_PERIPHERAL_FAULT_STATUS_BIT(sbit), .I_WARN(warn),
    .I_FAULT(fault), .I_MOTOR_ON(motor), .I_MANUAL_ABORT(mabort), .I_INPUT_TRIP(itrip),
    .I_CURRENT_NO_ON(cno), .I_SELFTEST_FAIL(stf), .I_SYS_ERR(syserr),
    .I_GROUP_WARN(gwarn), .I_LINK_OK(link), .O_FAULT_LAMP(lamps[4]),
    .O_STATE_RED(lamps[3]), .O_STATE_GREEN(lamps[2]), .O_DEVICE_RED(lamps[1]),
    .O_DEVICE_GREEN(lamps[0]));
  sdr_master_model master_u (.i_clk(clk), .i_echo_valid(ev), .i_echo(echo),
    .i_status_bit(sbit), .o_param_wr(pwr), .o_param(par), .o_fault_list(flist));
  // =====
  // Shared tasks
  // =====
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    rd <= !w;
    we <= w;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0);
    rd <= 1'b0;
    we <= 1'b0;
    // One wait state per request: answer seen at the second edge
    chk(n, 2);
    if (!w) chk(rdata, exp);
  endtask
  task automatic ask(input logic cls, input logic [1:0] junk, input logic [3:0] exp);
    logic [3:0] code;
    master_u.ask(cls, junk, code);
    chk(code, exp);
  endtask
  // Apply item inputs and let the held item settle
  task automatic setw(input logic [3:0] w, input logic [9:0] f);
    @(posedge clk);
    warn <= w;
    fault <= f;
    repeat (3) @(posedge clk);
  endtask
  // Lamp conditions: motor, abort, trip, system error, group warning, link lost
  task automatic cond(input logic [5:0] c);
    @(posedge clk);
    motor <= c[0];
    mabort <= c[1];
    itrip <= c[2];
    syserr <= {c[3], 5'h0};
    gwarn <= {3'h0, c[4]};
    link <= !c[5];
  endtask
  // Steady lamps must never drop; blinking ones must be seen both ways
  task automatic look(input logic [4:0] on, input logic [4:0] blink);
    logic [4:0] seen_on;
    logic [4:0] seen_off;
    seen_on = 5'h0;
    seen_off = 5'h0;
    repeat (4) @(posedge clk);
    repeat (12) begin
      @(posedge clk);
      seen_on |= lamps;
      seen_off |= ~lamps;
    end
    chk({27'h0, seen_on}, {27'h0, on | blink});
    chk({27'h0, seen_off}, {27'h0, ~on});
  endtask
  // =====
  // Scenarios
  // =====
  task automatic t_bus();
    bus(1'b0, sdr_pkg::OFS_CTRL, 32'h0, sdr_pkg::CTRL_RESET);
    bus(1'b1, sdr_pkg::OFS_CTRL, 32'hffff_ffff, 32'h0);
    bus(1'b0, sdr_pkg::OFS_CTRL, 32'h0, 32'h1);
    bus(1'b1, sdr_pkg::OFS_STATUS, 32'hffff_ffff, 32'h0);
    bus(1'b0, sdr_pkg::OFS_STATUS, 32'h0, 32'h0);
    bus(1'b1, 4'hc, 32'hffff_ffff, 32'h0);
    bus(1'b0, 4'hc, 32'h0, 32'h0);
  endtask
  // Clock enable low must freeze a blinking lamp where it stands
  task automatic t_freeze();
    logic [4:0] held;
    @(posedge clk);
    clk_en <= 1'b0;
    @(posedge clk);
    held = lamps;
    repeat (10) @(posedge clk);
    chk({27'h0, lamps}, {27'h0, held});
    clk_en <= 1'b1;
  endtask
  task automatic t_lamps();
    cond(6'h01);
    look(5'h05, 5'h00);
    cond(6'h00);
    look(5'h01, 5'h00);
    cond(6'h02);
    look(5'h01, 5'h0c);
    t_freeze();
    cond(6'h04);
    look(5'h01, 5'h0c);
    cond(6'h08);
    look(5'h13, 5'h00);
    cond(6'h11);
    look(5'h04, 5'h03);
    cond(6'h20);
    look(5'h10, 5'h00);
    cond(6'h00);
  endtask
  task automatic t_warn();
    for (int i = 0; i < 4; i++) begin
      setw(4'h1 << i, 10'h0);
      ask(1'b0, i[1:0], WCODE[i*4 +: 4]);
    end
    setw(4'h0, 10'h0);
    setw(4'hc, 10'h0);
    ask(1'b0, 2'b01, 4'h4);
    setw(4'h2, 10'h0);
    setw(4'h3, 10'h0);
    ask(1'b0, 2'b10, 4'ha);
    setw(4'h1, 10'h0);
    ask(1'b0, 2'b11, 4'hb);
    ask(1'b1, 2'b11, 4'h0);
  endtask
  task automatic t_fault();
    for (int i = 0; i < 10; i++) begin
      setw(4'h0, 10'h1 << i);
      ask(1'b1, i[2:1], FCODE[i*4 +: 4]);
    end
    chk(flist, 1);
    ask(1'b0, 2'b11, 4'h0);
    setw(4'h0, 10'h0);
    setw(4'h0, 10'h300);
    ask(1'b1, 2'b00, 4'h3);
    setw(4'h0, 10'h301);
    ask(1'b1, 2'b01, 4'h3);
    setw(4'h0, 10'h001);
    ask(1'b1, 2'b10, 4'ha);
    setw(4'h0, 10'h0);
    chk(sbit, 0);
  endtask
  task automatic t_deverr();
    @(posedge clk);
    stf <= 1'b1;
    @(posedge clk);
    stf <= 1'b0;
    look(5'h12, 5'h00);
    ask(1'b1, 2'b10, 4'h5);
    bus(1'b1, sdr_pkg::OFS_CTRL, 32'h0, 32'h0);
    bus(1'b0, sdr_pkg::OFS_STATUS, 32'h0, 32'h0001_8010);
    bus(1'b0, sdr_pkg::OFS_ECHO, 32'h0, 32'h0000_0550);
    ask(1'b1, 2'b01, 4'h5);
    @(posedge clk);
    cno <= 1'b1;
    @(posedge clk);
    cno <= 1'b0;
    look(5'h1a, 5'h00);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(sbit, 0);
    ask(1'b1, 2'b00, 4'h0);
  endtask
  // =====
  // Verdict and sequence
  // =====
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    look(5'h00, 5'h01);
    t_bus();
    ask(1'b0, 2'b11, 4'h0);
    t_lamps();
    t_warn();
    t_fault();
    t_deverr();
    summarize();
  end
  // Whole run needs about 410 cycles; this allows nearly fifty times that
  initial begin
    #200000;
    err_total++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    summarize();
  end
endmodule
`default_nettype wire

// file: logic/sdr_diag_reporter.sv
/*
  Diagnostic reporter of a motor starter slave: keeps pending warnings and
  faults, answers a parameter write with a 4-bit echo, drives the fault,
  state and device lamps, and exposes control/status over Avalon-MM.
  Assumes all inputs are synchronous to I_CLK and that the link layer hands
  over each parameter write as a one-cycle strobe with its four bits.
*/
// Chosen here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module sdr_diag_reporter #(
  parameter int FLASH_HALF = sdr_pkg::FLASH_HALF_CYCLES,
  parameter int FLICKER_HALF = sdr_pkg::FLICKER_HALF_CYCLES
) (
  // Clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic I_CLK_EN,
  // Avalon-MM register slave
  input wire logic [3:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // Parameter write from the fieldbus link and its echo
  input wire logic I_PARAM_WR,
  input wire logic [3:0] I_PARAM,
  output logic [3:0] O_ECHO,
  output logic O_ECHO_VALID,
  output logic O_PERIPHERAL_FAULT_STATUS_BIT,
  // Starter condition inputs
  input wire logic [3:0] I_WARN,
  input wire logic [9:0] I_FAULT,
  input wire logic I_MOTOR_ON,
  input wire logic I_MANUAL_ABORT,
  input wire logic I_INPUT_TRIP,
  input wire logic I_CURRENT_NO_ON,
  input wire logic I_SELFTEST_FAIL,
  input wire logic [5:0] I_SYS_ERR,
  input wire logic [3:0] I_GROUP_WARN,
  input wire logic I_LINK_OK,
  // Indicator lamps (yellow = red and green together)
  output logic O_FAULT_LAMP,
  output logic O_STATE_RED,
  output logic O_STATE_GREEN,
  output logic O_DEVICE_RED,
  output logic O_DEVICE_GREEN
);

  // ==========================================================================
  // Helper functions
  // ==========================================================================
  // Index of the lowest set bit, IDX_NONE when none is set
  function automatic logic [3:0] prio_pick(input logic [10:0] vec);
    logic [3:0] idx;
    idx = sdr_pkg::IDX_NONE;
    for (int k = 10; k >= 0; k--) begin
      if (vec[k]) begin
        idx = 4'(k);
      end
    end
    return idx;
  endfunction

  // Keep a held index while its item is present, else pick afresh
  function automatic logic [3:0] hold_or_pick(input logic [3:0] held,
                                              input logic [10:0] vec);
    logic [3:0] idx;
    idx = prio_pick(vec);
    if (held != sdr_pkg::IDX_NONE && vec[held]) begin
      idx = held;
    end
    return idx;
  endfunction

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [31:0] ctrl;                // Software control word
  logic dev_err;                    // Device error latch
  logic err_no_on;                  // Current-without-on latch
  logic err_selftest;               // Self-test failure latch
  logic startup_seen;               // A parameter write has arrived
  logic [10:0] fault_pend;          // Faults in priority order
  logic [10:0] warn_pend;           // Warnings in priority order, zero padded
  logic [3:0] warn_idx;             // Warning item being reported
  logic [3:0] fault_idx;            // Fault item being reported
  logic [3:0] next_warn_idx;
  logic [3:0] next_fault_idx;
  logic [3:0] warn_code;            // Code of the held warning
  logic [3:0] fault_code;           // Code of the held fault
  logic [3:0] last_echo;            // Last echo handed to the link
  logic [31:0] flash_cnt;           // Flash half-period counter
  logic [31:0] flicker_cnt;         // Flicker half-period counter
  logic flash_ph;                   // Flash phase, lamp on when high
  logic flicker_ph;                 // Flicker phase, lamp on when high
  logic bus_req;                    // A bus request is present
  logic bus_done;                   // Request is answered at this edge
  logic [31:0] next_rdata;
  logic next_fault_lamp;
  logic next_state_red;
  logic next_state_green;
  logic next_dev_red;
  logic next_dev_green;

  // ==========================================================================
  // Pending items
  // ==========================================================================
  // Device error joins the fault list at top priority
  assign fault_pend = {I_FAULT, dev_err};
  assign warn_pend = {7'h00, I_WARN};

  // Device error sources stay caught until a power-on reset
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      err_no_on <= 1'b0;
      err_selftest <= 1'b0;
      dev_err <= 1'b0;
    end else if (I_CLK_EN) begin
      // Only set terms: no command path clears these
      err_no_on <= err_no_on | I_CURRENT_NO_ON;
      err_selftest <= err_selftest | I_SELFTEST_FAIL;
      dev_err <= dev_err | I_CURRENT_NO_ON | I_SELFTEST_FAIL;
    end
  end

  // ==========================================================================
  // Item selection
  // ==========================================================================
  // Next held item per class: stick with it while present, else best one
  always_comb begin
    next_warn_idx = hold_or_pick(warn_idx, warn_pend);
    next_fault_idx = hold_or_pick(fault_idx, fault_pend);
  end

  // Held items; a better item never displaces one still present
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      warn_idx <= sdr_pkg::IDX_NONE;
      fault_idx <= sdr_pkg::IDX_NONE;
    end else if (I_CLK_EN) begin
      warn_idx <= next_warn_idx;
      fault_idx <= next_fault_idx;
    end
  end

  // Code lookup; index 0 is the lowest priority number
  always_comb begin
    warn_code = sdr_pkg::CODE_NONE;
    fault_code = sdr_pkg::CODE_NONE;
    if (warn_idx < 4'(sdr_pkg::NUM_WARN)) begin
      warn_code = sdr_pkg::WARN_CODES[warn_idx[1:0] * 4 +: 4];
    end
    if (fault_idx < 4'(sdr_pkg::NUM_FAULT)) begin
      // Codes of I_FAULT sit at indices 1..10, device error at 0
      fault_code = sdr_pkg::FAULT_CODES[fault_idx * 4 +: 4];
    end
  end

  // ==========================================================================
  // Parameter echo
  // ==========================================================================
  // One echo per parameter write, one cycle later; the A/B bit is the
  // master's own business, so only the class bit is looked at
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      O_ECHO <= sdr_pkg::CODE_NONE;
      O_ECHO_VALID <= 1'b0;
      last_echo <= sdr_pkg::CODE_NONE;
    end else if (I_CLK_EN) begin
      O_ECHO_VALID <= I_PARAM_WR;
      if (I_PARAM_WR) begin
        // Bits 1 to 3 take no part in the choice
        if (I_PARAM[sdr_pkg::PARAM_CLASS_BIT]) begin
          O_ECHO <= fault_code;
          last_echo <= fault_code;
        end else begin
          O_ECHO <= warn_code;
          last_echo <= warn_code;
        end
      end
    end
  end

  // Startup parameters count as received at the first write
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      startup_seen <= 1'b0;
    end else if (I_CLK_EN && I_PARAM_WR) begin
      startup_seen <= 1'b1;
    end
  end

  // Status bit the master copies into its fault list
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      O_PERIPHERAL_FAULT_STATUS_BIT <= 1'b0;
    end else if (I_CLK_EN) begin
      O_PERIPHERAL_FAULT_STATUS_BIT <= |fault_pend;
    end
  end

  // ==========================================================================
  // Blink timing
  // ==========================================================================
  // Free-running half-period counters; both lamps share them so every
  // flashing lamp on the unit blinks in step
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      flash_cnt <= 32'h0000_0000;
      flash_ph <= 1'b0;
    end else if (I_CLK_EN) begin
      if (flash_cnt >= 32'(FLASH_HALF - 1)) begin
        flash_cnt <= 32'h0000_0000;
        flash_ph <= ~flash_ph;
      end else begin
        flash_cnt <= flash_cnt + 32'h0000_0001;
      end
    end
  end

  // Faster phase for flickering
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      flicker_cnt <= 32'h0000_0000;
      flicker_ph <= 1'b0;
    end else if (I_CLK_EN) begin
      if (flicker_cnt >= 32'(FLICKER_HALF - 1)) begin
        flicker_cnt <= 32'h0000_0000;
        flicker_ph <= ~flicker_ph;
      end else begin
        flicker_cnt <= flicker_cnt + 32'h0000_0001;
      end
    end
  end

  // ==========================================================================
  // Lamp combinations
  // ==========================================================================
  // Highest severity first; later branches only apply with no error
  always_comb begin
    next_fault_lamp = 1'b0;
    next_state_red = 1'b0;
    next_state_green = 1'b0;
    next_dev_red = 1'b0;
    next_dev_green = 1'b0;
    if (err_no_on) begin
      // All red
      next_fault_lamp = 1'b1;
      next_state_red = 1'b1;
      next_dev_red = 1'b1;
    end else if (err_selftest) begin
      // State stays dark
      next_fault_lamp = 1'b1;
      next_dev_red = 1'b1;
    end else if (!I_LINK_OK) begin
      // Fault lamp alone
      next_fault_lamp = 1'b1;
    end else if (|I_SYS_ERR) begin
      // Device lamp steady yellow
      next_fault_lamp = 1'b1;
      next_dev_red = 1'b1;
      next_dev_green = 1'b1;
    end else if (|fault_pend) begin
      // Diagnostics available through the echo
      next_fault_lamp = 1'b1;
    end else if (|I_GROUP_WARN) begin
      // Flashing yellow, state green only while switched on
      next_dev_red = flash_ph;
      next_dev_green = flash_ph;
      next_state_green = I_MOTOR_ON;
    end else if (!ctrl[sdr_pkg::CTRL_FACTORY_INIT] || !startup_seen) begin
      // Not started up: flashing green device lamp
      next_dev_green = flash_ph;
    end else if (I_MANUAL_ABORT) begin
      // Flashing yellow state lamp
      next_state_red = flash_ph;
      next_state_green = flash_ph;
      next_dev_green = 1'b1;
    end else if (I_INPUT_TRIP) begin
      // Flickering yellow state lamp
      next_state_red = flicker_ph;
      next_state_green = flicker_ph;
      next_dev_green = 1'b1;
    end else begin
      // Normal operation
      next_state_green = I_MOTOR_ON;
      next_dev_green = 1'b1;
    end
  end

  // Lamp drivers, registered so outputs are glitch free
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      O_FAULT_LAMP <= 1'b0;
      O_STATE_RED <= 1'b0;
      O_STATE_GREEN <= 1'b0;
      O_DEVICE_RED <= 1'b0;
      O_DEVICE_GREEN <= 1'b0;
    end else if (I_CLK_EN) begin
      O_FAULT_LAMP <= next_fault_lamp;
      O_STATE_RED <= next_state_red;
      O_STATE_GREEN <= next_state_green;
      O_DEVICE_RED <= next_dev_red;
      O_DEVICE_GREEN <= next_dev_green;
    end
  end

  // ==========================================================================
  // Avalon-MM register slave
  // ==========================================================================
  // Fixed one wait state: waitrequest drops for one cycle after a
  // request is seen, which keeps read data registered
  assign bus_req = I_AVS_READ | I_AVS_WRITE;
  assign bus_done = bus_req & ~O_AVS_WAITREQUEST;

  // Read multiplexer; unmapped words read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (I_AVS_ADDRESS)
      sdr_pkg::OFS_CTRL: begin
        next_rdata = ctrl;
      end
      sdr_pkg::OFS_STATUS: begin
        next_rdata[sdr_pkg::ST_WARN_LSB +: 4] = I_WARN;
        next_rdata[sdr_pkg::ST_FAULT_LSB +: 11] = fault_pend;
        next_rdata[sdr_pkg::ST_DEV_ERR] = dev_err;
        next_rdata[sdr_pkg::ST_STARTUP] = startup_seen;
      end
      sdr_pkg::OFS_ECHO: begin
        next_rdata[sdr_pkg::EC_WARN_LSB +: 4] = warn_code;
        next_rdata[sdr_pkg::EC_FAULT_LSB +: 4] = fault_code;
        next_rdata[sdr_pkg::EC_LAST_LSB +: 4] = last_echo;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Handshake and read data
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      O_AVS_WAITREQUEST <= 1'b1;
      O_AVS_READDATA <= 32'h0000_0000;
    end else if (I_CLK_EN) begin
      if (!O_AVS_WAITREQUEST) begin
        O_AVS_WAITREQUEST <= 1'b1;
      end else if (bus_req) begin
        O_AVS_WAITREQUEST <= 1'b0;
        if (I_AVS_READ) begin
          O_AVS_READDATA <= next_rdata;
        end
      end
    end
  end

  // Control word; writes land at the edge the request completes.
  // No bit here can clear the device error latch.
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      ctrl <= sdr_pkg::CTRL_RESET;
    end else if (I_CLK_EN && bus_done && I_AVS_WRITE) begin
      if (I_AVS_ADDRESS == sdr_pkg::OFS_CTRL) begin
        ctrl <= {31'h0000_0000, I_AVS_WRITEDATA[sdr_pkg::CTRL_FACTORY_INIT]};
      end
    end
  end
endmodule

`default_nettype wire

// file: logic/sdr_pkg.sv
/*
  Shared constants of the starter diagnostic reporter: register map, field
  positions, reset values, echo codes in priority order and lamp timing.
  Assumes a 100 MHz system clock and a word-aligned Avalon-MM register bus.
*/
`default_nettype none

package sdr_pkg;

  // ==========================================================================
  // Clock and lamp timing
  // ==========================================================================
  localparam int CLK_MHZ = 100;             // System clock rate in MHz
  localparam int FLASH_HALF_MS = 250;       // Flashing lamp: half period in ms
  localparam int FLICKER_HALF_MS = 50;      // Flickering lamp: half period in ms
  localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * 1000 * CLK_MHZ;
  localparam int FLICKER_HALF_CYCLES = FLICKER_HALF_MS * 1000 * CLK_MHZ;

  // ==========================================================================
  // Register map (byte addresses, one 32-bit word each)
  // ==========================================================================
  localparam logic [3:0] OFS_CTRL = 4'h0;   // Control, read/write
  localparam logic [3:0] OFS_STATUS = 4'h4; // Pending items and latches, read
  localparam logic [3:0] OFS_ECHO = 4'h8;   // Current codes and last echo, read

  // CTRL fields
  localparam int CTRL_FACTORY_INIT = 0;     // Device has been factory initialised
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // STATUS fields
  localparam int ST_WARN_LSB = 0;           // Four warning/message pending bits
  localparam int ST_FAULT_LSB = 4;          // Eleven fault pending bits
  localparam int ST_DEV_ERR = 15;           // Device error latch
  localparam int ST_STARTUP = 16;           // Startup parameters seen

  // ECHO fields
  localparam int EC_WARN_LSB = 0;           // Code reported for warnings
  localparam int EC_FAULT_LSB = 4;          // Code reported for faults
  localparam int EC_LAST_LSB = 8;           // Last echo sent to the master

  // ==========================================================================
  // Echo codes, listed from highest priority (index 0) downward
  // ==========================================================================
  localparam int NUM_WARN = 4;
  localparam int NUM_FAULT = 11;
  localparam logic [3:0] CODE_NONE = 4'h0;  // Nothing pending, ranks lowest
  localparam logic [3:0] IDX_NONE = 4'hf;   // No item held
  // Prewarning 11, manual local 10, thermal model off 04, sensor off 12
  localparam logic [15:0] WARN_CODES = {4'hc, 4'h4, 4'ha, 4'hb};
  // Device err 05, low supply 10, no switch supply 06, bad param 14,
  // connector 09, short circuit 12, breaker 02, overload 04,
  // asymmetry 13, residual current 03, group fault 15
  localparam logic [43:0] FAULT_CODES = {4'hf, 4'h3, 4'hd, 4'h4, 4'h2, 4'hc,
                                         4'h9, 4'he, 4'h6, 4'ha, 4'h5};

  // Parameter bit that picks the echo class
  localparam int PARAM_CLASS_BIT = 0;

endpackage

`default_nettype wire
